// file: hw/sad_pkg.sv
// constants and types for the system address decoder
package sad_pkg;

  // ****************************************
  // bus widths
  // ****************************************
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned RGN_MSB = 31;
  localparam int unsigned RGN_LSB = 28;

  // ****************************************
  // 256MB region codes, address bits 31:28
  // ****************************************
  localparam logic [3:0] RGN_LOW    = 4'h0;
  localparam logic [3:0] RGN_ASYNC1 = 4'h1;
  localparam logic [3:0] RGN_ASYNC2 = 4'h2;
  localparam logic [3:0] RGN_ASYNC3 = 4'h3;
  localparam logic [3:0] RGN_CARD1  = 4'h4;
  localparam logic [3:0] RGN_CARD2  = 4'h5;
  localparam logic [3:0] RGN_ASYNC6 = 4'h6;
  localparam logic [3:0] RGN_ASYNC7 = 4'h7;
  localparam logic [3:0] RGN_SYNC0  = 4'hc;
  localparam logic [3:0] RGN_SYNC1  = 4'hd;
  localparam logic [3:0] RGN_SYNC2  = 4'he;
  localparam logic [3:0] RGN_HIGH   = 4'hf;

  // ****************************************
  // internal spans
  // ****************************************
  localparam logic [31:0] PERI_BASE   = 32'h8000_0000;
  localparam logic [31:0] AHBREG_BASE = 32'h8000_2000;
  localparam logic [31:0] RESV_BASE   = 32'h8000_3800;
  localparam logic [31:0] SRAM_BASE   = 32'hb000_0000;
  localparam logic [31:0] SRAM_END    = 32'hb001_4000;
  localparam int unsigned SRAM_WORDS  = 20480;
  localparam int unsigned SRAM_AW     = 15;
  localparam int unsigned WORD_LSB    = 2;

  // ****************************************
  // transfer sizes and boot capture
  // ****************************************
  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  localparam logic [1:0] SIZE_HALF   = 2'h1;
  localparam logic [1:0] SIZE_WORD   = 2'h2;
  localparam logic [1:0] BOOT_SETTLE = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        we;
    logic [1:0]  size;
  } sad_req_s;

  typedef struct packed {
    logic async_bank0_select_n;
    logic async_bank1_select_n;
    logic async_bank2_select_n;
    logic async_bank3_select_n;
    logic async_bank6_select;
    logic async_bank7_select;
    logic sync_bank0_select_n;
    logic sync_bank1_select_n;
    logic sync_bank2_select_n;
    logic sync_bank3_select_n;
    logic card_slot1_enable_n;
    logic card_slot2_enable_n;
  } sad_cs_s;

  localparam sad_cs_s CS_IDLE = 12'hf3f;

  typedef enum logic [4:0] {
    TGT_EXT  = 5'h01,
    TGT_PERI = 5'h02,
    TGT_REG  = 5'h04,
    TGT_SRAM = 5'h08,
    TGT_RESV = 5'h10
  } sad_tgt_e;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_EXT     = 6'h02,
    ST_REG     = 6'h04,
    ST_PSETUP  = 6'h08,
    ST_PENABLE = 6'h10,
    ST_SRAM    = 6'h20
  } sad_state_e;

  typedef struct packed {
    sad_tgt_e tgt;
    sad_cs_s  cs;
  } sad_dec_s;

endpackage

// file: hw/sad_sram.sv
// embedded sram with byte lane writes and registered read data
module sad_sram #(
  parameter int unsigned WORDS = sad_pkg::SRAM_WORDS,
  parameter int unsigned AW    = sad_pkg::SRAM_AW
) (
  // clock and enable
  input  wire logic                       core_clk_i,
  input  wire logic                       ce_i,
  // access
  input  wire logic                       en_i,
  input  wire logic                       we_i,
  input  wire logic [sad_pkg::BE_W-1:0]   be_i,
  input  wire logic [AW-1:0]              addr_i,
  input  wire logic [sad_pkg::DATA_W-1:0] wdata_i,
  // read data
  output logic      [sad_pkg::DATA_W-1:0] rdata_o
);

  // ****************************************
  // byte lanes, each lane its own array
  // ****************************************
  for (genvar g = 0; g < sad_pkg::BE_W; g++)
  begin : g_lane
    logic [7:0] mem [WORDS];

    always_ff @(posedge core_clk_i)
    begin
      if (ce_i && en_i && we_i && be_i[g])
      begin
        mem[addr_i] <= wdata_i[g*8 +: 8];
      end
    end

    // registered read of this lane
    always_ff @(posedge core_clk_i)
    begin
      if (ce_i && en_i)
      begin
        rdata_o[g*8 +: 8] <= mem[addr_i];
      end
    end
  end

endmodule

// file: hw/sad_decoder.sv
// system address decoder, arbiter and return-data multiplexer
module sad_decoder (
  // clock, reset, enable
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       ce_i,
  // boot strap pin, high for synchronous boot
  input  wire logic                       boot_sync_i,
  // processor master
  input  wire logic                       cpu_valid_i,
  input  wire sad_pkg::sad_req_s          cpu_req_i,
  output logic                            cpu_done_o,
  // dma master
  input  wire logic                       dma_valid_i,
  input  wire sad_pkg::sad_req_s          dma_req_i,
  output logic                            dma_done_o,
  // shared return data
  output logic      [sad_pkg::DATA_W-1:0] rdata_o,
  // shared address and write path
  output logic      [sad_pkg::ADDR_W-1:0] bus_addr_o,
  output logic      [sad_pkg::DATA_W-1:0] bus_wdata_o,
  output logic                            bus_we_o,
  output logic      [1:0]                 bus_size_o,
  // external bus port
  output logic                            ext_req_o,
  output sad_pkg::sad_cs_s                ext_sel_o,
  input  wire logic                       ext_ready_i,
  input  wire logic [sad_pkg::DATA_W-1:0] ext_rdata_i,
  // peripheral bridge
  output logic                            psel_o,
  output logic                            penable_o,
  input  wire logic                       pready_i,
  input  wire logic [sad_pkg::DATA_W-1:0] prdata_i,
  // internal register space
  output logic                            reg_sel_o,
  input  wire logic                       reg_ready_i,
  input  wire logic [sad_pkg::DATA_W-1:0] reg_rdata_i
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic sad_pkg::sad_dec_s sad_decode(
    input logic [31:0] addr,
    input logic        boot_sync
  );
    sad_pkg::sad_dec_s d;
    d.tgt = sad_pkg::TGT_EXT;
    d.cs  = sad_pkg::CS_IDLE;
    unique case (addr[sad_pkg::RGN_MSB:sad_pkg::RGN_LSB])
      sad_pkg::RGN_LOW:
      begin
        if (boot_sync)
          d.cs.sync_bank3_select_n = 1'b0;
        else
          d.cs.async_bank0_select_n = 1'b0;
      end
      sad_pkg::RGN_HIGH:
      begin
        if (boot_sync)
          d.cs.async_bank0_select_n = 1'b0;
        else
          d.cs.sync_bank3_select_n = 1'b0;
      end
      sad_pkg::RGN_ASYNC1: d.cs.async_bank1_select_n = 1'b0;
      sad_pkg::RGN_ASYNC2: d.cs.async_bank2_select_n = 1'b0;
      sad_pkg::RGN_ASYNC3: d.cs.async_bank3_select_n = 1'b0;
      sad_pkg::RGN_CARD1:  d.cs.card_slot1_enable_n = 1'b0;
      sad_pkg::RGN_CARD2:  d.cs.card_slot2_enable_n = 1'b0;
      sad_pkg::RGN_ASYNC6: d.cs.async_bank6_select = 1'b1;
      sad_pkg::RGN_ASYNC7: d.cs.async_bank7_select = 1'b1;
      sad_pkg::RGN_SYNC0:  d.cs.sync_bank0_select_n = 1'b0;
      sad_pkg::RGN_SYNC1:  d.cs.sync_bank1_select_n = 1'b0;
      sad_pkg::RGN_SYNC2:  d.cs.sync_bank2_select_n = 1'b0;
      default:
      begin
        if (addr >= sad_pkg::PERI_BASE && addr < sad_pkg::AHBREG_BASE)
          d.tgt = sad_pkg::TGT_PERI;
        else if (addr >= sad_pkg::AHBREG_BASE
                 && addr < sad_pkg::RESV_BASE)
          d.tgt = sad_pkg::TGT_REG;
        else if (addr >= sad_pkg::SRAM_BASE && addr < sad_pkg::SRAM_END)
          d.tgt = sad_pkg::TGT_SRAM;
        else
          d.tgt = sad_pkg::TGT_RESV;
      end
    endcase
    return d;
  endfunction

  function automatic logic [sad_pkg::BE_W-1:0] sad_byte_en(
    input logic [1:0] size,
    input logic [1:0] lsb
  );
    logic [sad_pkg::BE_W-1:0] be;
    be = 4'h0;
    unique case (size)
      sad_pkg::SIZE_BYTE: be = 4'h1 << lsb;
      sad_pkg::SIZE_HALF: be = lsb[1] ? 4'hc : 4'h3;
      default:            be = 4'hf;
    endcase
    return be;
  endfunction

  // ****************************************
  // boot mode capture
  // ****************************************
  logic       boot_meta_ff;
  logic       boot_pin_ff;
  logic [1:0] boot_cnt_ff;
  logic       boot_mode_ff;
  logic       boot_valid_ff;
  logic       nxt_boot_meta;
  logic       nxt_boot_pin;
  logic [1:0] nxt_boot_cnt;
  logic       nxt_boot_mode;
  logic       nxt_boot_valid;

  always_comb
  begin
    nxt_boot_meta  = boot_sync_i;
    nxt_boot_pin   = boot_meta_ff;
    nxt_boot_cnt   = boot_cnt_ff;
    nxt_boot_mode  = boot_mode_ff;
    nxt_boot_valid = boot_valid_ff;
    if (!boot_valid_ff)
    begin
      if (boot_cnt_ff == sad_pkg::BOOT_SETTLE)
      begin
        nxt_boot_mode  = boot_pin_ff;
        nxt_boot_valid = 1'b1;
      end
      else
      begin
        nxt_boot_cnt = boot_cnt_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      boot_meta_ff  <= 1'b0;
      boot_pin_ff   <= 1'b0;
      boot_cnt_ff   <= 2'h0;
      boot_mode_ff  <= 1'b0;
      boot_valid_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      boot_meta_ff  <= nxt_boot_meta;
      boot_pin_ff   <= nxt_boot_pin;
      boot_cnt_ff   <= nxt_boot_cnt;
      boot_mode_ff  <= nxt_boot_mode;
      boot_valid_ff <= nxt_boot_valid;
    end
  end

  // ****************************************
  // access sequencer
  // ****************************************
  sad_pkg::sad_state_e        state_ff;
  sad_pkg::sad_state_e        nxt_state;
  sad_pkg::sad_req_s          req;
  sad_pkg::sad_dec_s          dec;
  sad_pkg::sad_cs_s           cs_ff;
  sad_pkg::sad_cs_s           nxt_cs;
  logic                       owner_ff;
  logic                       nxt_owner;
  logic                       prio_dma_ff;
  logic                       nxt_prio_dma;
  logic                       cpu_done_ff;
  logic                       dma_done_ff;
  logic                       nxt_cpu_done;
  logic                       nxt_dma_done;
  logic [sad_pkg::DATA_W-1:0] rdata_ff;
  logic [sad_pkg::DATA_W-1:0] nxt_rdata;
  logic [sad_pkg::ADDR_W-1:0] addr_ff;
  logic [sad_pkg::ADDR_W-1:0] nxt_addr;
  logic [sad_pkg::DATA_W-1:0] wdata_ff;
  logic [sad_pkg::DATA_W-1:0] nxt_wdata;
  logic                       we_ff;
  logic                       nxt_we;
  logic [1:0]                 size_ff;
  logic [1:0]                 nxt_size;
  logic                       ext_req_ff;
  logic                       nxt_ext_req;
  logic                       psel_ff;
  logic                       nxt_psel;
  logic                       penable_ff;
  logic                       nxt_penable;
  logic                       reg_sel_ff;
  logic                       nxt_reg_sel;
  logic                       cpu_ok;
  logic                       dma_ok;
  logic                       pick_dma;
  logic                       fin;
  logic [sad_pkg::DATA_W-1:0] fin_data;
  logic                       mem_en;
  logic [sad_pkg::DATA_W-1:0] mem_rdata;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cs       = cs_ff;
    nxt_owner    = owner_ff;
    nxt_prio_dma = prio_dma_ff;
    nxt_cpu_done = 1'b0;
    nxt_dma_done = 1'b0;
    nxt_rdata    = rdata_ff;
    nxt_addr     = addr_ff;
    nxt_wdata    = wdata_ff;
    nxt_we       = we_ff;
    nxt_size     = size_ff;
    nxt_ext_req  = ext_req_ff;
    nxt_psel     = psel_ff;
    nxt_penable  = penable_ff;
    nxt_reg_sel  = reg_sel_ff;
    fin          = 1'b0;
    fin_data     = '0;
    mem_en       = 1'b0;
    cpu_ok       = cpu_valid_i && !cpu_done_ff;
    dma_ok       = dma_valid_i && !dma_done_ff;
    pick_dma     = dma_ok && (!cpu_ok || prio_dma_ff);
    req          = pick_dma ? dma_req_i : cpu_req_i;
    dec          = sad_decode(req.addr, boot_mode_ff);
    unique case (state_ff)
      sad_pkg::ST_IDLE:
      begin
        if (boot_valid_ff && (cpu_ok || dma_ok))
        begin
          nxt_owner    = pick_dma;
          nxt_prio_dma = !pick_dma;
          nxt_addr     = req.addr;
          nxt_wdata    = req.wdata;
          nxt_we       = req.we;
          nxt_size     = req.size;
          unique case (dec.tgt)
            sad_pkg::TGT_EXT:
            begin
              nxt_cs      = dec.cs;
              nxt_ext_req = 1'b1;
              nxt_state   = sad_pkg::ST_EXT;
            end
            sad_pkg::TGT_PERI:
            begin
              nxt_psel  = 1'b1;
              nxt_state = sad_pkg::ST_PSETUP;
            end
            sad_pkg::TGT_REG:
            begin
              nxt_reg_sel = 1'b1;
              nxt_state   = sad_pkg::ST_REG;
            end
            sad_pkg::TGT_SRAM:
            begin
              mem_en    = 1'b1;
              nxt_state = sad_pkg::ST_SRAM;
            end
            default:
            begin
              fin = 1'b1;
            end
          endcase
        end
      end
      sad_pkg::ST_EXT:
      begin
        if (ext_ready_i)
        begin
          nxt_ext_req = 1'b0;
          nxt_cs      = sad_pkg::CS_IDLE;
          fin         = 1'b1;
          fin_data    = ext_rdata_i;
        end
      end
      sad_pkg::ST_REG:
      begin
        if (reg_ready_i)
        begin
          nxt_reg_sel = 1'b0;
          fin         = 1'b1;
          fin_data    = reg_rdata_i;
        end
      end
      sad_pkg::ST_PSETUP:
      begin
        nxt_penable = 1'b1;
        nxt_state   = sad_pkg::ST_PENABLE;
      end
      sad_pkg::ST_PENABLE:
      begin
        if (pready_i)
        begin
          nxt_psel    = 1'b0;
          nxt_penable = 1'b0;
          fin         = 1'b1;
          fin_data    = prdata_i;
        end
      end
      sad_pkg::ST_SRAM:
      begin
        fin      = 1'b1;
        fin_data = mem_rdata;
      end
      default:
      begin
        nxt_state = sad_pkg::ST_IDLE;
      end
    endcase
    if (fin)
    begin
      nxt_rdata    = nxt_we ? '0 : fin_data;
      nxt_cpu_done = !nxt_owner;
      nxt_dma_done = nxt_owner;
      nxt_state    = sad_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff    <= sad_pkg::ST_IDLE;
      cs_ff       <= sad_pkg::CS_IDLE;
      owner_ff    <= 1'b0;
      prio_dma_ff <= 1'b0;
      cpu_done_ff <= 1'b0;
      dma_done_ff <= 1'b0;
      rdata_ff    <= '0;
      addr_ff     <= '0;
      wdata_ff    <= '0;
      we_ff       <= 1'b0;
      size_ff     <= sad_pkg::SIZE_BYTE;
      ext_req_ff  <= 1'b0;
      psel_ff     <= 1'b0;
      penable_ff  <= 1'b0;
      reg_sel_ff  <= 1'b0;
    end
    else if (ce_i)
    begin
      state_ff    <= nxt_state;
      cs_ff       <= nxt_cs;
      owner_ff    <= nxt_owner;
      prio_dma_ff <= nxt_prio_dma;
      cpu_done_ff <= nxt_cpu_done;
      dma_done_ff <= nxt_dma_done;
      rdata_ff    <= nxt_rdata;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      we_ff       <= nxt_we;
      size_ff     <= nxt_size;
      ext_req_ff  <= nxt_ext_req;
      psel_ff     <= nxt_psel;
      penable_ff  <= nxt_penable;
      reg_sel_ff  <= nxt_reg_sel;
    end
  end

  // ****************************************
  // embedded sram
  // ****************************************
  sad_sram #(
    .WORDS (sad_pkg::SRAM_WORDS),
    .AW    (sad_pkg::SRAM_AW)
  ) u_sram (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .en_i       (mem_en),
    .we_i       (req.we),
    .be_i       (sad_byte_en(req.size, req.addr[1:0])),
    .addr_i     (req.addr[sad_pkg::WORD_LSB +: sad_pkg::SRAM_AW]),
    .wdata_i    (req.wdata),
    .rdata_o    (mem_rdata)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign cpu_done_o  = cpu_done_ff;
  assign dma_done_o  = dma_done_ff;
  assign rdata_o     = rdata_ff;
  assign bus_addr_o  = addr_ff;
  assign bus_wdata_o = wdata_ff;
  assign bus_we_o    = we_ff;
  assign bus_size_o  = size_ff;
  assign ext_req_o   = ext_req_ff;
  assign ext_sel_o   = cs_ff;
  assign psel_o      = psel_ff;
  assign penable_o   = penable_ff;
  assign reg_sel_o   = reg_sel_ff;

endmodule

// file: verification/sad_target_model.sv
// responder model for the external, bridge and register targets
module sad_target_model (
  // clock, reset and wait states
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic [1:0]  wait_i,
  // strobes from the decoder
  input  wire logic        ext_req_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        reg_sel_i,
  input  wire logic [31:0] bus_addr_i,
  // answers
  output logic             ext_ready_o,
  output logic             pready_o,
  output logic             reg_ready_o,
  output logic      [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       act;
  logic       hit;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic       tgl_ff;
  logic       nxt_tgl;

  assign act         = ext_req_i | (psel_i & penable_i) | reg_sel_i;
  assign hit         = act && cnt_ff == wait_i;
  assign ext_ready_o = ext_req_i & hit;
  assign pready_o    = psel_i & penable_i & hit;
  assign reg_ready_o = reg_sel_i & hit;
  // data outside the answer cycle toggles every clock
  assign rdata_o     = hit ? ~bus_addr_i : {32{tgl_ff}};

  always_comb
  begin
    nxt_cnt = (act && !hit) ? cnt_ff + 2'h1 : 2'h0;
    nxt_tgl = ~tgl_ff;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 2'h0;
      tgl_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tgl_ff <= nxt_tgl;
    end
  end
endmodule

// file: verification/sad_decoder_properties.sv
// concurrent checks on the decoder ports
module sad_decoder_properties (
  // watched ports
  input wire logic                       core_clk_i,
  input wire logic                       rst_i,
  input wire logic                       boot_sync_i,
  input wire logic                       cpu_done_o,
  input wire logic                       dma_done_o,
  input wire logic [sad_pkg::DATA_W-1:0] rdata_o,
  input wire logic [sad_pkg::ADDR_W-1:0] bus_addr_o,
  input wire logic                       bus_we_o,
  input wire logic                       ext_req_o,
  input wire sad_pkg::sad_cs_s           ext_sel_o,
  input wire logic                       ext_ready_i,
  input wire logic [sad_pkg::DATA_W-1:0] ext_rdata_i,
  input wire logic                       psel_o,
  input wire logic                       penable_o,
  input wire logic                       pready_i,
  input wire logic                       reg_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic boot_ff;
  logic done;
  logic resv;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [11:0] exp_cs(input logic [3:0] r, input logic b);
    logic [3:0] i;
    case (r)
      4'h0: i = b ? 4'h9 : 4'h0;
      4'hf: i = b ? 4'h0 : 4'h9;
      4'h4: i = 4'ha;
      4'h5: i = 4'hb;
      4'h6: i = 4'h4;
      4'h7: i = 4'h5;
      4'hc: i = 4'h6;
      4'hd: i = 4'h7;
      4'he: i = 4'h8;
      default: i = r;
    endcase
    return sad_pkg::CS_IDLE ^ (12'h800 >> i);
  endfunction

  assign done = cpu_done_o | dma_done_o;
  assign resv = (bus_addr_o >= sad_pkg::RESV_BASE
              && bus_addr_o < sad_pkg::SRAM_BASE)
             || (bus_addr_o >= sad_pkg::SRAM_END && bus_addr_o[31:28] == 4'hb);

  // mode captured while reset holds
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      boot_ff <= boot_sync_i;
  end

  // ****************************************
  // properties
  // ****************************************
  property p_sel_map;
    ext_req_o |-> ext_sel_o == exp_cs(bus_addr_o[31:28], boot_ff);
  endproperty
  a_sel_map: assert property (p_sel_map)
    else $error("chip select does not match region");

  property p_ext_hold;
    ext_req_o && !ext_ready_i |=>
      ext_req_o && $stable(ext_sel_o) && $stable(bus_addr_o);
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("external access moved before completion");

  property p_ext_end;
    ext_req_o && ext_ready_i |=>
      !ext_req_o && done && (bus_we_o || rdata_o == $past(ext_rdata_i));
  endproperty
  a_ext_end: assert property (p_ext_end)
    else $error("external completion wrong");

  property p_grant_idle;
    $changed(bus_addr_o) |->
      !$past(ext_req_o) && !$past(psel_o) && !$past(reg_sel_o);
  endproperty
  a_grant_idle: assert property (p_grant_idle)
    else $error("grant while access in progress");

  property p_bridge_seq;
    $rose(psel_o) |-> !penable_o ##1 (psel_o && penable_o);
  endproperty
  a_bridge_seq: assert property (p_bridge_seq)
    else $error("bridge setup then enable broken");

  property p_pwait;
    psel_o && penable_o && !pready_i |=> psel_o && penable_o;
  endproperty
  a_pwait: assert property (p_pwait)
    else $error("bridge strobe dropped early");

  property p_resv_quiet;
    resv |-> !ext_req_o && !psel_o && !reg_sel_o;
  endproperty
  a_resv_quiet: assert property (p_resv_quiet)
    else $error("reserved span selected a target");

  property p_zero_rd;
    done && (bus_we_o || resv) |-> rdata_o == 32'h0000_0000;
  endproperty
  a_zero_rd: assert property (p_zero_rd)
    else $error("nonzero read data on write or reserved");
endmodule

bind sad_decoder sad_decoder_properties sad_decoder_properties_inst (
  .core_clk_i, .rst_i, .boot_sync_i, .cpu_done_o, .dma_done_o, .rdata_o,
  .bus_addr_o, .bus_we_o, .ext_req_o, .ext_sel_o, .ext_ready_i,
  .ext_rdata_i, .psel_o, .penable_o, .pready_i, .reg_sel_o
);

// file: verification/sad_decoder_bench.sv
// self-checking bench for the system address decoder
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("wrong value at %0t: got %h want %h", $time, g, e); \
    end \
  end

module sad_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk_i;
  logic              rst_i;
  logic              ce_i;
  logic              boot_sync_i;
  logic [1:0]        vld;
  sad_pkg::sad_req_s req [2];
  wire  [1:0]        done;
  wire  [34:0]       wpath;
  logic [31:0]       rdata_o;
  logic [31:0]       t_rdata;
  logic [31:0]       bus_addr_o;
  logic              ext_req_o;
  logic              ext_ready_i;
  logic              psel_o;
  logic              penable_o;
  logic              pready_i;
  logic              reg_sel_o;
  logic              reg_ready_i;
  logic [1:0]        wt;
  int                n_errors;
  int                checked;

  sad_decoder sad_decoder_inst (
    .core_clk_i, .rst_i, .ce_i, .boot_sync_i,
    .cpu_valid_i (vld[0]), .cpu_req_i (req[0]), .cpu_done_o (done[0]),
    .dma_valid_i (vld[1]), .dma_req_i (req[1]), .dma_done_o (done[1]),
    .rdata_o, .bus_addr_o, .bus_wdata_o (wpath[34:3]),
    .bus_we_o (wpath[2]), .bus_size_o (wpath[1:0]),
    .ext_req_o, .ext_sel_o (), .ext_ready_i, .ext_rdata_i (t_rdata),
    .psel_o, .penable_o, .pready_i, .prdata_i (t_rdata),
    .reg_sel_o, .reg_ready_i, .reg_rdata_i (t_rdata)
  );

  sad_target_model sad_target_model_inst (
    .core_clk_i, .rst_i, .wait_i (wt), .ext_req_i (ext_req_o),
    .psel_i (psel_o), .penable_i (penable_o), .reg_sel_i (reg_sel_o),
    .bus_addr_i (bus_addr_o), .ext_ready_o (ext_ready_i),
    .pready_o (pready_i), .reg_ready_o (reg_ready_i), .rdata_o (t_rdata)
  );

  always #20ns core_clk_i = ~core_clk_i;

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic do_reset(input logic b);
    boot_sync_i <= b;
    rst_i       <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask

  // one access, checks data and cycles to done
  task automatic acc(input int m, input logic [31:0] a, input logic we,
                     input logic [1:0] sz, input logic [31:0] wd,
                     input logic [31:0] exp, input int lat);
    int n;
    n = 0;
    @(posedge core_clk_i);
    req[m] <= '{a, wd, we, sz};
    vld[m] <= 1'b1;
    do
    begin
      @(negedge core_clk_i);
      n++;
    end
    while (done[m] !== 1'b1 && n < 40);
    `CHK(rdata_o, exp)
    `CHK(wpath, {wd, we, sz})
    `CHK(n, lat + 1)
    @(posedge core_clk_i);
    vld[m] <= 1'b0;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regions(input logic b);
    logic [31:0] a;
    do_reset(b);
    boot_sync_i <= ~b;
    for (int r = 0; r < 16; r++)
    begin
      if (r < 8 || r > 11)
      begin
        a = {r[3:0], 28'h000_0040};
        wt <= r[1:0];
        acc(r % 2, a, 1'b0, sad_pkg::SIZE_WORD, 32'h0, ~a, 2 + r % 4);
      end
    end
    $display("regions test done, boot %0d", b);
  endtask

  task automatic t_internal;
    logic [31:0] pa [4] = '{32'h8000_0000, 32'h8000_1ffc,
                            32'h8000_2000, 32'h8000_37fc};
    logic [31:0] ra [4] = '{32'h8000_3800, 32'hafff_fffc,
                            32'hb001_4000, 32'hbfff_fffc};
    for (int i = 0; i < 4; i++)
    begin
      wt <= 2'(i);
      acc(i % 2, pa[i], 1'b0, 2'h2, 32'h0, ~pa[i], (i < 2 ? 3 : 2) + i);
    end
    for (int i = 0; i < 4; i++)
      acc(i % 2, ra[i], i[0], 2'h2, 32'hffff_ffff, 32'h0, 1);
    $display("internal spans test done");
  endtask

  task automatic t_sram;
    acc(0, 32'hb001_3ffc, 1'b1, 2'h2, 32'h1122_3344, 32'h0, 2);
    acc(1, 32'hb001_3ffd, 1'b1, 2'h0, 32'h0000_ab00, 32'h0, 2);
    acc(0, 32'hb001_3ffe, 1'b1, 2'h1, 32'hcdef_0000, 32'h0, 2);
    acc(1, 32'hb000_0000, 1'b1, 2'h2, 32'h5555_aaaa, 32'h0, 2);
    acc(0, 32'hb001_3ffc, 1'b0, 2'h2, 32'h0, 32'hcdef_ab44, 2);
    acc(1, 32'hb000_0000, 1'b0, 2'h2, 32'h0, 32'h5555_aaaa, 2);
    ce_i <= 1'b0;
    acc(0, 32'hb000_0000, 1'b0, 2'h2, 32'h0, 32'h5555_aaaa, 39);
    ce_i <= 1'b1;
    $display("sram test done");
  endtask

  task automatic t_arbit;
    logic w;
    int   n;
    do_reset(1'b0);
    n      = 0;
    wt     <= 2'h2;
    req[0] <= '{32'h1000_0100, 32'h0, 1'b0, sad_pkg::SIZE_WORD};
    req[1] <= '{32'h2000_0200, 32'h0, 1'b0, sad_pkg::SIZE_WORD};
    vld    <= 2'h3;
    for (int j = 0; j < 2; j++)
    begin
      do
      begin
        @(negedge core_clk_i);
        n++;
      end
      while (done === 2'h0 && n < 40);
      w = done[1];
      `CHK(w, j[0])
      `CHK(rdata_o, ~req[w].addr)
      @(posedge core_clk_i);
      vld[w] <= 1'b0;
    end
    $display("arbitration test done");
  endtask

  initial
  begin
    core_clk_i  = 1'b0;
    rst_i       = 1'b1;
    ce_i        = 1'b1;
    boot_sync_i = 1'b0;
    vld         = 2'h0;
    req[0]      = '0;
    req[1]      = '0;
    wt          = 2'h0;
    n_errors    = 0;
    checked     = 0;
    t_regions(1'b1);
    t_regions(1'b0);
    t_internal;
    t_sram;
    t_arbit;
    tally_and_finish;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    tally_and_finish;
  end
endmodule
